//--- src/fault_status_pkg.sv
// Operation
// - Read-only 16-bit part identity word, two bytes, low nibble set per build.
// - Clear-all command 0x03 clears every stored status bit at once; summary bits 6 and 11 follow live inputs.
// - Clear-all releases the alert output if it is being driven.
// - A fault still present after clearing sets its bit and alert again.
// - Clear-all completes within 10 us; only faults in its own cycle are erased.
// - Clearing faults never restarts a latched-off channel.
// - Latched channel restarts after off-then-on command, or soft restart.
// - Peak values clear on command 0xE3 and on every reset.
// - Mask bit set stops alert from that bit; the bit still sets.
// - Process call with register code returns that register's mask byte.
// - No mask for summaries, common or pin flags; bad code flags invalid data.
// - Default masks zero, vendor flags mask 0x11.
// - Summary low bit 7 busy, bit 5 overvoltage, bit 4 overcurrent.
// - Summary bit 3 reads 0; bit 2 temperature, 1 comm, 0 other.
// - Summary bit 6 set whenever the channel delivers no output power.
// - Summary word 0x79 low byte equals the one-byte summary of that page.
// - High byte bits 15..12 voltage, current, input, vendor; 11 power bad.
// - Any unmasked status bit raises an alert, but of the input flags only bit 7; output off and power bad never alert.
// - Status bytes 0x7A..0x7E and 0x80; input and comm flags shared.
// - Pin readback word 0xE5, common flags byte 0xEF, info word 0xB6.
// - Writing 1 to a supported status bit clears only that bit.
// - Any vendor flag set sets the vendor bit of the summary word.
package fault_status_pkg;
	localparam logic [7:0] CODE_CLEAR_ALL = 8'h03;
	localparam logic [7:0] CODE_ALERT_MASK = 8'h1B;
	localparam logic [7:0] CODE_SUMMARY_LOW = 8'h78;
	localparam logic [7:0] CODE_SUMMARY_FULL = 8'h79;
	localparam logic [7:0] CODE_OUTV = 8'h7A;
	localparam logic [7:0] CODE_OUTI = 8'h7B;
	localparam logic [7:0] CODE_INPUT = 8'h7C;
	localparam logic [7:0] CODE_TEMP = 8'h7D;
	localparam logic [7:0] CODE_COMM = 8'h7E;
	localparam logic [7:0] CODE_VENDOR = 8'h80;
	localparam logic [7:0] CODE_MFG_INFO = 8'hB6;
	localparam logic [7:0] CODE_PEAK_RESET = 8'hE3;
	localparam logic [7:0] CODE_PIN_STATE = 8'hE5;
	localparam logic [7:0] CODE_PART_ID = 8'hE7;
	localparam logic [7:0] CODE_COMMON = 8'hEF;
	// Transaction kinds handed over by the bus front end
	localparam logic [2:0] KIND_SEND = 3'h0;
	localparam logic [2:0] KIND_WR_BYTE = 3'h1;
	localparam logic [2:0] KIND_WR_WORD = 3'h2;
	localparam logic [2:0] KIND_RD_BYTE = 3'h3;
	localparam logic [2:0] KIND_RD_WORD = 3'h4;
	localparam logic [2:0] KIND_PROC_CALL = 3'h5;
	// Supported bits per detailed register
	localparam logic [7:0] SUPP_OUTV = 8'hFE;
	localparam logic [7:0] SUPP_OUTI = 8'hA0;
	localparam logic [7:0] SUPP_INPUT = 8'hAA;
	localparam logic [7:0] ALERT_INPUT = 8'h80;
	localparam logic [7:0] SUPP_TEMP = 8'hD0;
	localparam logic [7:0] SUPP_COMM = 8'hFB;
	localparam logic [7:0] SUPP_VENDOR = 8'hFF;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MASK_VENDOR_RESET = 8'h11;
	localparam int COMM_BAD_CMD = 7;
	localparam int COMM_BAD_DATA = 6;
	localparam int SUM_BUSY = 7;
	// Part identity; value is arbitrary
	localparam logic [15:0] PART_ID = 16'hA5C0;
	localparam int SYS_CLK_PERIOD_NS = 100;
	localparam int CLEAR_TIME_NS = 10000;
	localparam logic [6:0] CLEAR_CYCLES = 7'(CLEAR_TIME_NS / SYS_CLK_PERIOD_NS);
	localparam logic [1:0] LINK_IDLE = 2'b01;
	localparam logic [1:0] LINK_WAIT = 2'b10;
endpackage

//--- src/link_cmd_crossing.sv
`timescale 1ns/10ps
`default_nettype none
module link_cmd_crossing (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic linkReqValid,
	input wire logic [2:0] linkReqKind,
	input wire logic [7:0] linkReqCode,
	input wire logic [15:0] linkReqData,
	output logic linkReqReady,
	output logic linkRspValid,
	output logic [15:0] linkRspData,
	output logic sysReqPulse,
	output logic [2:0] sysKind,
	output logic [7:0] sysCode,
	output logic [15:0] sysData,
	input wire logic [15:0] sysRspData,
	input wire logic sysRspDone
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} link_state_t;
	typedef struct packed {
		logic rstS1;
		logic rstS2;
		link_state_t state;
		logic reqTog;
		logic ackS1;
		logic ackS2;
		logic ackSeen;
		logic [2:0] kind;
		logic [7:0] code;
		logic [15:0] data;
		logic rspValid;
		logic [15:0] rspData;
	} link_regs_t;
	typedef struct packed {
		logic reqS1;
		logic reqS2;
		logic reqSeen;
		logic ackTog;
	} sys_regs_t;
	link_regs_t l, next_l;
	sys_regs_t s, next_s;

	always_comb begin
		next_l = l;
		next_l.rstS1 = sys_rst;
		next_l.rstS2 = l.rstS1;
		next_l.ackS1 = s.ackTog;
		next_l.ackS2 = l.ackS1;
		next_l.rspValid = 1'b0;
		case (l.state)
			ST_IDLE: begin
				if (linkReqValid) begin
					next_l.kind = linkReqKind;
					next_l.code = linkReqCode;
					next_l.data = linkReqData;
					next_l.reqTog = ~l.reqTog;
					next_l.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Reply word is stable in the system domain once the toggle lands
				if (l.ackS2 != l.ackSeen) begin
					next_l.ackSeen = l.ackS2;
					next_l.rspData = sysRspData;
					next_l.rspValid = 1'b1;
					next_l.state = ST_IDLE;
				end
			end
			default: next_l.state = ST_IDLE;
		endcase
		if (l.rstS2) begin
			next_l.state = ST_IDLE;
			next_l.rspValid = 1'b0;
			next_l.reqTog = 1'b0;
			next_l.ackSeen = l.ackS2;
		end
	end

	always_ff @(posedge linkClk) begin
		l <= next_l;
	end

	always_comb begin
		next_s = s;
		next_s.reqS1 = l.reqTog;
		next_s.reqS2 = s.reqS1;
		if (s.reqS2 != s.reqSeen)
			next_s.reqSeen = s.reqS2;
		if (sysRspDone)
			next_s.ackTog = ~s.ackTog;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign linkReqReady = (l.state == ST_IDLE) && !l.rstS2;
	assign linkRspValid = l.rspValid;
	assign linkRspData = l.rspData;
	assign sysReqPulse = s.reqS2 ^ s.reqSeen;
	assign sysKind = l.kind;
	assign sysCode = l.code;
	assign sysData = l.data;
endmodule
`default_nettype wire

//--- src/pmbus_fault_status_alert.sv
`timescale 1ns/10ps
`default_nettype none
module pmbus_fault_status_alert (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic linkReqValid,
	input wire logic [2:0] linkReqKind,
	input wire logic [7:0] linkReqCode,
	input wire logic [15:0] linkReqData,
	output logic linkReqReady,
	output logic linkRspValid,
	output logic [15:0] linkRspData,
	input wire logic pageSel,
	input wire logic [1:0][7:0] outvCond,
	input wire logic [1:0][7:0] outiCond,
	input wire logic [1:0][7:0] tempCond,
	input wire logic [1:0][7:0] vendorCond,
	input wire logic [7:0] inputCond,
	input wire logic [7:0] commCond,
	input wire logic busyCond,
	input wire logic [1:0] outputOn,
	input wire logic [1:0] powerGood,
	input wire logic [1:0] runPin,
	input wire logic [1:0] operationOn,
	input wire logic softRestart,
	input wire logic [1:0] latchOffEvt,
	input wire logic [15:0] mfgInfo,
	input wire logic [15:0] pinState,
	input wire logic [5:0] commonBits,
	output logic alertOut,
	output logic alertOe,
	output logic [1:0] latchedOff,
	output logic clearPeaks,
	output logic clearBusy
);
	typedef struct packed {
		logic [1:0][7:0] outv;
		logic [1:0][7:0] outi;
		logic [1:0][7:0] temp;
		logic [1:0][7:0] vendor;
		logic [7:0] inFlags;
		logic [7:0] comm;
		logic busyFlag;
		logic [1:0][7:0] maskOutv;
		logic [1:0][7:0] maskOuti;
		logic [1:0][7:0] maskTemp;
		logic [1:0][7:0] maskVendor;
		logic [7:0] maskInput;
		logic [7:0] maskComm;
		logic [15:0] rspData;
		logic rspDone;
		logic alertOe;
		logic clearPeaks;
		logic [6:0] clearCnt;
		logic [1:0] runS1;
		logic [1:0] runS2;
		logic [1:0] latched;
		logic [1:0] armed;
	} state_t;
	state_t s, next_s;

	logic reqPulse;
	logic [2:0] reqKind;
	logic [7:0] reqCode;
	logic [15:0] reqData;
	logic [1:0][7:0] sumLow;
	logic [1:0][7:0] sumHigh;
	logic anyAlert;
	logic clearAll;

	link_cmd_crossing u_crossing (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.linkClk(linkClk),
		.linkReqValid(linkReqValid),
		.linkReqKind(linkReqKind),
		.linkReqCode(linkReqCode),
		.linkReqData(linkReqData),
		.linkReqReady(linkReqReady),
		.linkRspValid(linkRspValid),
		.linkRspData(linkRspData),
		.sysReqPulse(reqPulse),
		.sysKind(reqKind),
		.sysCode(reqCode),
		.sysData(reqData),
		.sysRspData(s.rspData),
		.sysRspDone(s.rspDone)
	);

	// Supported bits of a maskable register; zero marks a code without a mask
	function automatic logic [7:0] suppBits(input logic [7:0] code);
		if (code == fault_status_pkg::CODE_OUTV)
			return fault_status_pkg::SUPP_OUTV;
		else if (code == fault_status_pkg::CODE_OUTI)
			return fault_status_pkg::SUPP_OUTI;
		else if (code == fault_status_pkg::CODE_INPUT)
			return fault_status_pkg::SUPP_INPUT;
		else if (code == fault_status_pkg::CODE_TEMP)
			return fault_status_pkg::SUPP_TEMP;
		else if (code == fault_status_pkg::CODE_COMM)
			return fault_status_pkg::SUPP_COMM;
		else if (code == fault_status_pkg::CODE_VENDOR)
			return fault_status_pkg::SUPP_VENDOR;
		else
			return 8'h00;
	endfunction

	// Summaries are derived, never stored, so they can not drift from the detail
	for (genvar p = 0; p < 2; p++) begin : g_summary
		always_comb begin
			sumLow[p] = {s.busyFlag, ~outputOn[p], s.outv[p][7], s.outi[p][7], 1'b0,
				|s.temp[p], |s.comm, |s.vendor[p] | |s.inFlags};
			sumHigh[p] = {|s.outv[p], |s.outi[p], |s.inFlags, |s.vendor[p],
				~powerGood[p], 3'h0};
		end
	end

	always_comb begin
		anyAlert = s.busyFlag;
		for (int p = 0; p < 2; p++) begin
			anyAlert = anyAlert | |(s.outv[p] & ~s.maskOutv[p]) | |(s.outi[p] & ~s.maskOuti[p])
				| |(s.temp[p] & ~s.maskTemp[p]) | |(s.vendor[p] & ~s.maskVendor[p]);
		end
		anyAlert = anyAlert | |(s.inFlags & fault_status_pkg::ALERT_INPUT & ~s.maskInput)
			| |(s.comm & ~s.maskComm);
	end

	assign clearAll = reqPulse && reqKind == fault_status_pkg::KIND_SEND
		&& reqCode == fault_status_pkg::CODE_CLEAR_ALL;

	always_comb begin
		logic pg;
		logic wr;
		logic rd;
		logic [7:0] clr;
		logic [7:0] mcode;
		logic [7:0] mval;
		logic badCmd;
		logic badData;
		next_s = s;
		pg = pageSel;
		wr = reqPulse && (reqKind == fault_status_pkg::KIND_WR_BYTE
			|| reqKind == fault_status_pkg::KIND_WR_WORD);
		rd = reqPulse && (reqKind == fault_status_pkg::KIND_RD_BYTE
			|| reqKind == fault_status_pkg::KIND_RD_WORD);
		clr = wr ? reqData[7:0] & suppBits(reqCode) : 8'h00;
		mcode = reqData[7:0];
		mval = reqData[15:8];
		badCmd = 1'b0;
		badData = 1'b0;
		next_s.rspDone = reqPulse;
		next_s.clearPeaks = 1'b0;
		next_s.runS1 = runPin;
		next_s.runS2 = s.runS1;
		if (s.clearCnt != 7'h00)
			next_s.clearCnt = s.clearCnt - 7'h01;
		// Write one to clear; a fault present in the same cycle wins
		if (reqCode == fault_status_pkg::CODE_OUTV)
			next_s.outv[pg] = s.outv[pg] & ~clr;
		if (reqCode == fault_status_pkg::CODE_OUTI)
			next_s.outi[pg] = s.outi[pg] & ~clr;
		if (reqCode == fault_status_pkg::CODE_TEMP)
			next_s.temp[pg] = s.temp[pg] & ~clr;
		if (reqCode == fault_status_pkg::CODE_VENDOR)
			next_s.vendor[pg] = s.vendor[pg] & ~clr;
		if (reqCode == fault_status_pkg::CODE_INPUT)
			next_s.inFlags = s.inFlags & ~clr;
		if (reqCode == fault_status_pkg::CODE_COMM)
			next_s.comm = s.comm & ~clr;
		if (wr && (reqCode == fault_status_pkg::CODE_SUMMARY_LOW
			|| reqCode == fault_status_pkg::CODE_SUMMARY_FULL) && reqData[fault_status_pkg::SUM_BUSY])
			next_s.busyFlag = 1'b0;
		if (reqPulse) begin
			next_s.rspData = 16'h0000;
			if (reqKind == fault_status_pkg::KIND_SEND) begin
				if (reqCode == fault_status_pkg::CODE_CLEAR_ALL)
					next_s.clearCnt = fault_status_pkg::CLEAR_CYCLES;
				else if (reqCode == fault_status_pkg::CODE_PEAK_RESET)
					next_s.clearPeaks = 1'b1;
				else
					badCmd = 1'b1;
			end else if (reqCode == fault_status_pkg::CODE_ALERT_MASK) begin
				if (reqKind == fault_status_pkg::KIND_WR_WORD
					|| reqKind == fault_status_pkg::KIND_PROC_CALL) begin
					if (suppBits(mcode) == 8'h00)
						badData = 1'b1;
					else if (reqKind == fault_status_pkg::KIND_PROC_CALL) begin
						if (mcode == fault_status_pkg::CODE_OUTV)
							next_s.rspData = {8'h00, s.maskOutv[pg]};
						else if (mcode == fault_status_pkg::CODE_OUTI)
							next_s.rspData = {8'h00, s.maskOuti[pg]};
						else if (mcode == fault_status_pkg::CODE_TEMP)
							next_s.rspData = {8'h00, s.maskTemp[pg]};
						else if (mcode == fault_status_pkg::CODE_VENDOR)
							next_s.rspData = {8'h00, s.maskVendor[pg]};
						else if (mcode == fault_status_pkg::CODE_INPUT)
							next_s.rspData = {8'h00, s.maskInput};
						else
							next_s.rspData = {8'h00, s.maskComm};
					end else begin
						// Unsupported bits never become maskable
						mval = mval & suppBits(mcode);
						if (mcode == fault_status_pkg::CODE_OUTV)
							next_s.maskOutv[pg] = mval;
						else if (mcode == fault_status_pkg::CODE_OUTI)
							next_s.maskOuti[pg] = mval;
						else if (mcode == fault_status_pkg::CODE_TEMP)
							next_s.maskTemp[pg] = mval;
						else if (mcode == fault_status_pkg::CODE_VENDOR)
							next_s.maskVendor[pg] = mval;
						else if (mcode == fault_status_pkg::CODE_INPUT)
							next_s.maskInput = mval;
						else
							next_s.maskComm = mval;
					end
				end else
					badCmd = 1'b1;
			end else if (rd) begin
				if (reqCode == fault_status_pkg::CODE_SUMMARY_LOW)
					next_s.rspData = {8'h00, sumLow[pg]};
				else if (reqCode == fault_status_pkg::CODE_SUMMARY_FULL)
					next_s.rspData = {sumHigh[pg], sumLow[pg]};
				else if (reqCode == fault_status_pkg::CODE_OUTV)
					next_s.rspData = {8'h00, s.outv[pg]};
				else if (reqCode == fault_status_pkg::CODE_OUTI)
					next_s.rspData = {8'h00, s.outi[pg]};
				else if (reqCode == fault_status_pkg::CODE_INPUT)
					next_s.rspData = {8'h00, s.inFlags};
				else if (reqCode == fault_status_pkg::CODE_TEMP)
					next_s.rspData = {8'h00, s.temp[pg]};
				else if (reqCode == fault_status_pkg::CODE_COMM)
					next_s.rspData = {8'h00, s.comm};
				else if (reqCode == fault_status_pkg::CODE_VENDOR)
					next_s.rspData = {8'h00, s.vendor[pg]};
				else if (reqCode == fault_status_pkg::CODE_PIN_STATE)
					next_s.rspData = pinState;
				else if (reqCode == fault_status_pkg::CODE_COMMON)
					next_s.rspData = {8'h00, ~s.alertOe, s.clearCnt == 7'h00, commonBits};
				else if (reqCode == fault_status_pkg::CODE_MFG_INFO)
					next_s.rspData = mfgInfo;
				else if (reqCode == fault_status_pkg::CODE_PART_ID)
					next_s.rspData = fault_status_pkg::PART_ID;
				else
					badCmd = 1'b1;
			end else if (!wr || suppBits(reqCode) == 8'h00 && reqCode != fault_status_pkg::CODE_SUMMARY_LOW
				&& reqCode != fault_status_pkg::CODE_SUMMARY_FULL)
				badCmd = 1'b1;
		end
		if (badCmd)
			next_s.comm[fault_status_pkg::COMM_BAD_CMD] = 1'b1;
		if (badData)
			next_s.comm[fault_status_pkg::COMM_BAD_DATA] = 1'b1;
		// Clear-all wins over faults in its own cycle; faults still present return next cycle
		if (clearAll) begin
			next_s.outv = '0;
			next_s.outi = '0;
			next_s.temp = '0;
			next_s.vendor = '0;
			next_s.inFlags = 8'h00;
			next_s.comm = 8'h00;
			next_s.busyFlag = 1'b0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				next_s.outv[p] = next_s.outv[p] | outvCond[p] & fault_status_pkg::SUPP_OUTV;
				next_s.outi[p] = next_s.outi[p] | outiCond[p] & fault_status_pkg::SUPP_OUTI;
				next_s.temp[p] = next_s.temp[p] | tempCond[p] & fault_status_pkg::SUPP_TEMP;
				next_s.vendor[p] = next_s.vendor[p] | vendorCond[p];
			end
			next_s.inFlags = next_s.inFlags | inputCond & fault_status_pkg::SUPP_INPUT;
			next_s.comm = next_s.comm | commCond & fault_status_pkg::SUPP_COMM;
			next_s.busyFlag = next_s.busyFlag | busyCond;
		end
		next_s.alertOe = anyAlert && !clearAll;
		// Latch-off is untouched by any clear; only off-then-on or soft restart frees it
		for (int p = 0; p < 2; p++) begin
			if (s.latched[p] && !(s.runS2[p] && operationOn[p]))
				next_s.armed[p] = 1'b1;
			if (softRestart || s.armed[p] && s.runS2[p] && operationOn[p]) begin
				next_s.latched[p] = 1'b0;
				next_s.armed[p] = 1'b0;
			end
			if (latchOffEvt[p])
				next_s.latched[p] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.clearPeaks <= 1'b1;
			s.maskOutv <= {2{fault_status_pkg::MASK_RESET}};
			s.maskOuti <= {2{fault_status_pkg::MASK_RESET}};
			s.maskTemp <= {2{fault_status_pkg::MASK_RESET}};
			s.maskVendor <= {2{fault_status_pkg::MASK_VENDOR_RESET}};
			s.maskInput <= fault_status_pkg::MASK_RESET;
			s.maskComm <= fault_status_pkg::MASK_RESET;
		end else
			s <= next_s;
	end

	assign alertOut = 1'b0;
	assign alertOe = s.alertOe;
	assign latchedOff = s.latched;
	assign clearPeaks = s.clearPeaks;
	assign clearBusy = s.clearCnt != 7'h00;

	property p_clear_release;
		@(posedge sys_clk) disable iff (sys_rst) clearAll |=> !alertOe;
	endproperty
	a_clear_release: assert property (p_clear_release) else $error("alert held across clear");

	property p_clear_zero;
		@(posedge sys_clk) disable iff (sys_rst) clearAll |=> s.comm == 8'h00 && s.outv == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("status survived clear-all");

	property p_fault_persists;
		@(posedge sys_clk) disable iff (sys_rst)
			clearAll && outvCond[1][7] ##1 outvCond[1][7] |=> s.outv[1][7] ##1 alertOe;
	endproperty
	a_fault_persists: assert property (p_fault_persists) else $error("persisting fault lost");

	property p_alert_cause;
		@(posedge sys_clk) disable iff (sys_rst) alertOe |-> $past(anyAlert);
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("alert without unmasked bit");

	property p_peak_clear;
		@(posedge sys_clk) disable iff (sys_rst)
			reqPulse && reqKind == fault_status_pkg::KIND_SEND
			&& reqCode == fault_status_pkg::CODE_PEAK_RESET |=> clearPeaks ##1 !clearPeaks;
	endproperty
	a_peak_clear: assert property (p_peak_clear) else $error("peak clear pulse wrong");

	property p_summary_low;
		@(posedge sys_clk) disable iff (sys_rst)
			reqPulse && reqKind == fault_status_pkg::KIND_RD_BYTE
			&& reqCode == fault_status_pkg::CODE_SUMMARY_LOW
			|=> s.rspData[3] == 1'b0
			&& s.rspData[6] == ($past(pageSel) ? !$past(outputOn[1]) : !$past(outputOn[0]));
	endproperty
	a_summary_low: assert property (p_summary_low) else $error("summary low byte wrong");

	property p_summary_word;
		@(posedge sys_clk) disable iff (sys_rst)
			reqPulse && reqKind == fault_status_pkg::KIND_RD_WORD
			&& reqCode == fault_status_pkg::CODE_SUMMARY_FULL
			|=> s.rspData[7:0] == $past(sumLow[pageSel]) && s.rspData[10:8] == 3'h0;
	endproperty
	a_summary_word: assert property (p_summary_word) else $error("summary word mismatch");

	property p_latch_kept;
		@(posedge sys_clk) disable iff (sys_rst) clearAll && s.latched[0] && !softRestart
			&& !s.armed[0] |=> s.latched[0];
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("clear restarted channel");

	property p_bad_mask_code;
		@(posedge sys_clk) disable iff (sys_rst)
			reqPulse && reqKind == fault_status_pkg::KIND_WR_WORD
			&& reqCode == fault_status_pkg::CODE_ALERT_MASK
			&& reqData[7:0] == fault_status_pkg::CODE_SUMMARY_LOW && !clearAll
			|=> s.comm[fault_status_pkg::COMM_BAD_DATA];
	endproperty
	a_bad_mask_code: assert property (p_bad_mask_code) else $error("bad mask code not flagged");
endmodule
`default_nettype wire

//--- tb/link_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
	input wire logic linkClk,
	input wire logic reqTgl,
	input wire logic [2:0] kind,
	input wire logic [7:0] code,
	input wire logic [15:0] data,
	input wire logic linkReqReady,
	input wire logic linkRspValid,
	input wire logic [15:0] linkRspData,
	output logic linkReqValid,
	output logic [2:0] linkReqKind,
	output logic [7:0] linkReqCode,
	output logic [15:0] linkReqData,
	output logic doneTgl,
	output logic [15:0] rdata
);
	logic busy;
	logic seenTgl;
	initial begin
		{linkReqValid, busy, seenTgl, doneTgl} = 4'h0;
		{linkReqKind, linkReqCode, linkReqData, rdata} = 43'h0;
	end
	always @(posedge linkClk) begin
		if (linkReqValid && linkReqReady) begin
			linkReqValid <= 1'b0;
			// Released code and data lines do not keep the old value; kind does
			linkReqCode <= ~linkReqCode;
			linkReqData <= ~linkReqData;
			busy <= 1'b1;
		end else if (busy && linkRspValid) begin
			rdata <= linkRspData;
			busy <= 1'b0;
			doneTgl <= ~doneTgl;
		end else if (!busy && !linkReqValid && reqTgl != seenTgl) begin
			seenTgl <= reqTgl;
			linkReqValid <= 1'b1;
			linkReqKind <= kind;
			linkReqCode <= code;
			linkReqData <= data;
		end
	end
endmodule
`default_nettype wire

//--- tb/test_pmbus_fault_status_alert.sv
`timescale 1ns/10ps
`default_nettype none
module test_pmbus_fault_status_alert;
	logic sys_clk, sys_rst, linkClk, linkReqValid, linkReqReady, linkRspValid, pageSel;
	logic [2:0] linkReqKind, kind;
	logic [7:0] linkReqCode, code, inputCond, commCond;
	logic [15:0] linkReqData, linkRspData, data, rdata, mfgInfo, pinState;
	logic [1:0][7:0] outvCond, outiCond, tempCond, vendorCond;
	logic busyCond, softRestart, alertOut, alertOe, clearPeaks, clearBusy, reqTgl, doneTgl;
	logic [1:0] outputOn, powerGood, runPin, operationOn, latchOffEvt, latchedOff;
	logic [5:0] commonBits;
	int bad_count = 0, num_checks = 0, peakCount = 0;
	pmbus_fault_status_alert uut (.sys_clk, .sys_rst, .linkClk, .linkReqValid, .linkReqKind,
		.linkReqCode, .linkReqData, .linkReqReady, .linkRspValid, .linkRspData, .pageSel,
		.outvCond, .outiCond, .tempCond, .vendorCond, .inputCond, .commCond, .busyCond,
		.outputOn, .powerGood, .runPin, .operationOn, .softRestart, .latchOffEvt, .mfgInfo,
		.pinState, .commonBits, .alertOut, .alertOe, .latchedOff, .clearPeaks, .clearBusy);
	link_host_model host (.linkClk, .reqTgl, .kind, .code, .data, .linkReqReady, .linkRspValid,
		.linkRspData, .linkReqValid, .linkReqKind, .linkReqCode, .linkReqData, .doneTgl, .rdata);
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		linkClk = 0;
		#7;
		forever #32 linkClk = ~linkClk;
	end
	always @(posedge sys_clk) peakCount += (clearPeaks === 1'b1);
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic [2:0] k, input logic [7:0] c, input logic [15:0] d);
		int n;
		logic t;
		t = doneTgl;
		n = 0;
		{kind, code, data} = {k, c, d};
		reqTgl = ~reqTgl;
		while (doneTgl === t && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 400) begin
			bad_count++;
			stop_test();
		end
		@(negedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] c);
		xfer(fault_status_pkg::KIND_RD_BYTE, c, 16'h0000);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] v);
		xfer(fault_status_pkg::KIND_WR_BYTE, c, {8'h00, v});
	endtask
	task automatic mask(input logic [7:0] c, input logic [7:0] m, input logic rdBack);
		if (rdBack) xfer(fault_status_pkg::KIND_PROC_CALL, fault_status_pkg::CODE_ALERT_MASK, {8'h00, c});
		else xfer(fault_status_pkg::KIND_WR_WORD, fault_status_pkg::CODE_ALERT_MASK, {m, c});
	endtask
	task automatic snd(input logic [7:0] c);
		xfer(fault_status_pkg::KIND_SEND, c, 16'h0000);
	endtask
	task automatic wait3();
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic t_defaults();
		mask(fault_status_pkg::CODE_VENDOR, 8'h00, 1);
		chk("maskVendor", rdata[7:0], 8'h11);
		mask(fault_status_pkg::CODE_TEMP, 8'h00, 1);
		chk("maskTemp", rdata[7:0], 8'h00);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_PART_ID, 16'h0000);
		chk("partId", rdata, fault_status_pkg::PART_ID);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_PIN_STATE, 16'h0000);
		chk("pins", rdata, pinState);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_MFG_INFO, 16'h0000);
		chk("info", rdata, mfgInfo);
		rd(fault_status_pkg::CODE_COMMON);
		chk("common", rdata[7:0], {2'b11, commonBits});
	endtask
	task automatic t_alert();
		tempCond[0] = 8'h40;
		wait3();
		chk("alertSet", alertOe, 1'b1);
		chk("alertLevel", alertOut, 1'b0);
		rd(fault_status_pkg::CODE_TEMP);
		chk("temp", rdata[7:0], 8'h40);
		rd(fault_status_pkg::CODE_SUMMARY_LOW);
		chk("sumLow", rdata[7:0], 8'h04);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_SUMMARY_FULL, 16'h0000);
		chk("sumWord", rdata, 16'h0004);
		pageSel = 1;
		rd(fault_status_pkg::CODE_TEMP);
		chk("tempPage1", rdata[7:0], 8'h00);
		pageSel = 0;
		tempCond[0] = 8'h00;
		wr(fault_status_pkg::CODE_TEMP, 8'h40);
		rd(fault_status_pkg::CODE_TEMP);
		chk("tempW1c", rdata[7:0], 8'h00);
		chk("alertGone", alertOe, 1'b0);
	endtask
	task automatic t_mask();
		mask(fault_status_pkg::CODE_TEMP, 8'h40, 0);
		mask(fault_status_pkg::CODE_TEMP, 8'h00, 1);
		chk("maskBack", rdata[7:0], 8'h40);
		tempCond[0] = 8'h40;
		wait3();
		chk("maskedAlert", alertOe, 1'b0);
		rd(fault_status_pkg::CODE_TEMP);
		chk("maskedBit", rdata[7:0], 8'h40);
		tempCond[0] = 8'h00;
		wr(fault_status_pkg::CODE_TEMP, 8'h40);
		mask(fault_status_pkg::CODE_SUMMARY_LOW, 8'hFF, 0);
		rd(fault_status_pkg::CODE_COMM);
		chk("badMask", rdata[7:0], 8'h40);
	endtask
	task automatic t_clear();
		int p;
		snd(fault_status_pkg::CODE_CLEAR_ALL);
		chk("clrBusy", clearBusy, 1'b1);
		chk("clrAlert", alertOe, 1'b0);
		rd(fault_status_pkg::CODE_COMM);
		chk("clrComm", rdata[7:0], 8'h00);
		outvCond[1] = 8'h80;
		wait3();
		snd(fault_status_pkg::CODE_CLEAR_ALL);
		chk("refault", alertOe, 1'b1);
		pageSel = 1;
		rd(fault_status_pkg::CODE_OUTV);
		chk("outvP1", rdata[7:0], 8'h80);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_SUMMARY_FULL, 16'h0000);
		chk("sumP1", rdata, 16'h8020);
		outvCond[1] = 8'h00;
		wr(fault_status_pkg::CODE_OUTV, 8'h80);
		pageSel = 0;
		repeat (100) @(negedge sys_clk);
		chk("clrDone", clearBusy, 1'b0);
		p = peakCount;
		snd(fault_status_pkg::CODE_PEAK_RESET);
		chk("peaks", 16'(peakCount - p), 16'h0001);
	endtask
	task automatic t_summary();
		{outputOn[0], powerGood[0], vendorCond[0]} = {2'b00, 8'h10};
		wait3();
		chk("vendMasked", alertOe, 1'b0);
		xfer(fault_status_pkg::KIND_RD_WORD, fault_status_pkg::CODE_SUMMARY_FULL, 16'h0000);
		chk("sumOff", rdata, 16'h1841);
		{outputOn[0], powerGood[0], vendorCond[0]} = {2'b11, 8'h00};
		wr(fault_status_pkg::CODE_VENDOR, 8'h10);
		busyCond = 1;
		@(negedge sys_clk);
		busyCond = 0;
		rd(fault_status_pkg::CODE_SUMMARY_LOW);
		chk("busy", rdata, 16'h0080);
		chk("busyAlert", alertOe, 1'b1);
		wr(fault_status_pkg::CODE_SUMMARY_LOW, 8'h80);
		rd(fault_status_pkg::CODE_SUMMARY_LOW);
		chk("busyClr", rdata, 16'h0000);
	endtask
	task automatic t_latch();
		latchOffEvt[0] = 1;
		@(negedge sys_clk);
		latchOffEvt[0] = 0;
		snd(fault_status_pkg::CODE_CLEAR_ALL);
		chk("stayOff", latchedOff, 2'b01);
		runPin[0] = 0;
		repeat (5) @(negedge sys_clk);
		runPin[0] = 1;
		repeat (5) @(negedge sys_clk);
		chk("rerun", latchedOff, 2'b00);
		latchOffEvt[1] = 1;
		@(negedge sys_clk);
		chk("latch1", latchedOff, 2'b10);
		{latchOffEvt[1], softRestart} = 2'b01;
		@(negedge sys_clk);
		softRestart = 0;
		wait3();
		chk("soft", latchedOff, 2'b00);
	endtask
	initial begin
		{pageSel, busyCond, softRestart, reqTgl, inputCond, commCond} = 20'h0;
		{outvCond, outiCond, tempCond, vendorCond, latchOffEvt} = 66'h0;
		{outputOn, powerGood, runPin, operationOn} = 8'hFF;
		{mfgInfo, pinState, commonBits} = {16'h1E2D, 16'h3C4B, 6'h2A};
		{kind, code, data} = 27'h0;
		sys_rst = 1;
		repeat (2) @(negedge sys_clk);
		chk("peakRst", clearPeaks, 1'b1);
		sys_rst = 0;
		repeat (6) @(negedge sys_clk);
		t_defaults();
		t_alert();
		t_mask();
		t_clear();
		t_summary();
		t_latch();
		stop_test();
	end
endmodule
`default_nettype wire
